// ---- logic/external_interrupt_detect.sv ----
// external interrupt channel 1: filter, edge detect, latch, registers
//
// Added by the designer: strobed register access.
`default_nettype none

module external_interrupt_detect
  import ext_int_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic [ext_int_pkg::ADDR_W-1:0] addr,
  input  wire logic [ext_int_pkg::DATA_W-1:0] wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output var  logic [ext_int_pkg::DATA_W-1:0] rdata,
  input  wire logic                          ext_pin,
  input  wire logic                          mode_slow,
  input  wire logic                          lf_tick,
  input  wire logic                          int_ack,
  output var  logic                          irq
);
  import ext_int_pkg::*;

  // ==========================================================
  // state
  logic [7:0]            enables_reg;
  logic [7:0]            ctrl_reg;
  logic [7:0]            status_reg;
  logic [7:0]            status_next;
  logic [7:0]            mask_reg;
  logic [7:0]            rdata_reg;
  logic                  irq_reg;
  logic [GEAR_DIV_W-1:0] gear_cnt_reg;
  logic [1:0]            lf_cnt_reg;
  logic [1:0]            filt_cnt_reg;
  logic                  filt_level_reg;
  logic                  filt_prev_reg;
  logic                  level_flag_reg;
  logic                  ch_en;
  logic                  sample_en;
  logic                  rise;
  logic                  fall;
  logic                  req;
  logic [1:0]            trig;
  logic [1:0]            rate;

  assign ch_en = enables_reg[CH1_EN_BIT];
  assign trig  = ctrl_reg[TRIG_LSB +: 2];
  assign rate  = ctrl_reg[RATE_LSB +: 2];

  // ==========================================================
  // helpers
  function automatic logic gear_due(input logic [1:0]            r,
                                    input logic [GEAR_DIV_W-1:0] c);
    logic due;
    due = 1'b0;
    case (r)
      RATE_DIV1:  due = 1'b1;
      RATE_DIV4:  due = (c[1:0] == 2'h0);
      RATE_DIV8:  due = (c[2:0] == 3'h0);
      RATE_DIV16: due = (c == 4'h0);
      default:    due = 1'b0;
    endcase
    return due;
  endfunction

  function automatic logic is_hit(input logic [11:0] a,
                                  input logic [11:0] target);
    return a == target;
  endfunction

  // ==========================================================
  // sample rate dividers
  // the divider only runs with the channel enabled: this stands in for
  // the stopped channel clock, so it restarts from zero on enable
  always_ff @(posedge clk_sys) begin
    if (!nrst || !ch_en) begin
      gear_cnt_reg <= 4'h0;
    end else begin
      gear_cnt_reg <= gear_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst || !ch_en) begin
      lf_cnt_reg <= 2'h0;
    end else if (lf_tick) begin
      lf_cnt_reg <= lf_cnt_reg + 2'h1;
    end
  end

  always_comb begin
    if (!ch_en) begin
      sample_en = 1'b0;
    end else if (mode_slow) begin
      sample_en = lf_tick && (lf_cnt_reg == SLOW_TICK_LAST);
    end else begin
      sample_en = gear_due(rate, gear_cnt_reg);
    end
  end

  // ==========================================================
  // noise filter
  // a level must differ on FILTER_SAMPLES samples in a row; a matching
  // sample restarts the count, so short glitches never get through
  always_ff @(posedge clk_sys) begin
    if (!nrst || !ch_en) begin
      filt_cnt_reg   <= 2'h0;
      filt_level_reg <= 1'b0;
    end else if (sample_en) begin
      if (ext_pin == filt_level_reg) begin
        filt_cnt_reg <= 2'h0;
      end else if (filt_cnt_reg == FILTER_SAMPLES - 2'h1) begin
        filt_cnt_reg   <= 2'h0;
        filt_level_reg <= ext_pin;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 2'h1;
      end
    end
  end

  // ==========================================================
  // edge detection on the filtered level only
  always_ff @(posedge clk_sys) begin
    if (!nrst || !ch_en) begin
      filt_prev_reg <= 1'b0;
    end else begin
      filt_prev_reg <= filt_level_reg;
    end
  end

  assign rise = filt_level_reg && !filt_prev_reg;
  assign fall = !filt_level_reg && filt_prev_reg;

  always_comb begin
    req = 1'b0;
    case (trig)
      TRIG_RISE: req = rise;
      TRIG_FALL: req = fall;
      TRIG_BOTH: req = rise || fall;
      default:   req = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      level_flag_reg <= 1'b0;
    end else if (req) begin
      level_flag_reg <= filt_level_reg;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      enables_reg <= ENABLES_RESET;
    end else if (wr && is_hit(addr, ENABLES_ADDR)) begin
      enables_reg <= wdata & ENABLES_WMASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_reg <= CTRL1_RESET;
    end else if (wr && is_hit(addr, CTRL1_ADDR) && ch_en) begin
      ctrl_reg <= {4'h0, wdata[3:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mask_reg <= MASK_RESET;
    end else if (wr && is_hit(addr, MASK_ADDR)) begin
      mask_reg <= {7'h00, wdata[REQ1_BIT]};
    end
  end

  // ==========================================================
  // interrupt latch
  // a request in the same cycle as an accept or a clear wins
  always_comb begin
    status_next = status_reg;
    if (int_ack) begin
      status_next[REQ1_BIT] = 1'b0;
    end
    if (wr && is_hit(addr, STATUS_ADDR) && wdata[REQ1_BIT]) begin
      status_next[REQ1_BIT] = 1'b0;
    end
    if (req) begin
      status_next[REQ1_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // irq follows the latch ANDed with the mask bit, with one cycle of lag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (!nrst || !rd) begin
      rdata_reg <= 8'h00;
    end else begin
      case (1'b1)
        is_hit(addr, ENABLES_ADDR): rdata_reg <= enables_reg;
        is_hit(addr, CTRL1_ADDR):
          rdata_reg <= {3'h0, level_flag_reg, ctrl_reg[3:0]};
        is_hit(addr, STATUS_ADDR):  rdata_reg <= status_reg;
        is_hit(addr, MASK_ADDR):    rdata_reg <= mask_reg;
        default:                    rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign irq   = irq_reg;

  // ==========================================================
  // checks
  chk_filter_feeds_edge: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    req |-> (filt_level_reg != filt_prev_reg))
    else $error("request without a filtered level change");

  chk_rise_sets_latch: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ch_en && trig == TRIG_RISE && rise) |=> status_reg[REQ1_BIT])
    else $error("rising edge did not set the latch");

  chk_reserved_silent: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (trig == 2'h3 || (trig == TRIG_FALL && rise)) |-> !req)
    else $error("request under reserved or wrong trigger");

  chk_disabled_stopped: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !ch_en |-> !sample_en ##1 (gear_cnt_reg == 4'h0 && !filt_level_reg))
    else $error("disabled channel kept running");

  chk_ctrl_write_lock: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (wr && addr == CTRL1_ADDR && !ch_en) |=> $stable(ctrl_reg))
    else $error("control changed while channel disabled");

  chk_enables_top_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rd && addr == ENABLES_ADDR) |=> (rdata[7:6] == 2'h0))
    else $error("enable bits 7 and 6 not zero");

  chk_ctrl_top_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (rd && addr == CTRL1_ADDR) |=> (rdata[7:5] == 3'h0))
    else $error("control bits 7 to 5 not zero");

  chk_level_capture: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    req |=> (level_flag_reg == $past(filt_level_reg)))
    else $error("level flag does not match filtered level");

  chk_latch_holds: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (status_reg[REQ1_BIT] && !int_ack && !(wr && addr == STATUS_ADDR))
    |=> status_reg[REQ1_BIT])
    else $error("latch dropped without accept or clear");

  chk_slow_rate: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (mode_slow && sample_en) |-> (lf_tick && lf_cnt_reg == 2'h3))
    else $error("slow mode sampled off the quarter tick");

  chk_div4_rate: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ch_en && !mode_slow && rate == RATE_DIV4 && sample_en)
    |=> !sample_en [*3])
    else $error("divide by four sampled too often");

  chk_filter_settle: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $changed(filt_level_reg) && ch_en && $past(ch_en)
    |-> ($past(filt_cnt_reg) == 2'h2 && $past(sample_en)))
    else $error("filter passed a level too early");

  chk_set_beats_clear: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    req |=> status_reg[REQ1_BIT])
    else $error("request lost against accept or clear");

  chk_ack_clears: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (int_ack && !req) |=> !status_reg[REQ1_BIT])
    else $error("accept did not clear the latch");

  chk_irq_on_latch: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (status_reg[REQ1_BIT] && mask_reg[REQ1_BIT]) |=> irq)
    else $error("unmasked latch did not raise irq");

  chk_irq_off_latch: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !(status_reg[REQ1_BIT] && mask_reg[REQ1_BIT]) |=> !irq)
    else $error("irq high without an unmasked latch");

  chk_div1_every: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (ch_en && !mode_slow && rate == RATE_DIV1) |-> sample_en)
    else $error("full rate missed a sample");

  cov_rise_req: cover property (
    @(posedge clk_sys) disable iff (!nrst) (trig == TRIG_RISE && req));
  cov_both_req: cover property (
    @(posedge clk_sys) disable iff (!nrst) (trig == TRIG_BOTH && fall && req));
  cov_irq_ack: cover property (
    @(posedge clk_sys) disable iff (!nrst) (irq && int_ack));
  cov_slow_req: cover property (
    @(posedge clk_sys) disable iff (!nrst) (mode_slow && req));

endmodule

`default_nettype wire

// ---- pkg/ext_int_pkg.sv ----
// constants for the external interrupt detect block
`default_nettype none

package ext_int_pkg;

  // ==========================================================
  // bus geometry
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 8;

  // ==========================================================
  // register byte addresses
  localparam logic [11:0] ENABLES_ADDR    = 12'hF77;
  localparam logic [11:0] CTRL1_ADDR      = 12'hFD8;
  localparam logic [11:0] STATUS_ADDR     = 12'hFE0;
  localparam logic [11:0] MASK_ADDR       = 12'hFE1;

  // ==========================================================
  // reset values and writable fields
  localparam logic [7:0]  ENABLES_RESET   = 8'h00;
  localparam logic [7:0]  ENABLES_WMASK   = 8'h3F;
  localparam logic [7:0]  CTRL1_RESET     = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'h00;

  // ==========================================================
  // field positions
  localparam int unsigned CH1_EN_BIT      = 1;
  localparam int unsigned RATE_LSB        = 0;
  localparam int unsigned TRIG_LSB        = 2;
  localparam int unsigned LEVEL_BIT       = 4;
  localparam int unsigned REQ1_BIT        = 0;

  // ==========================================================
  // field encodings
  localparam logic [1:0]  TRIG_RISE       = 2'h0;
  localparam logic [1:0]  TRIG_FALL       = 2'h1;
  localparam logic [1:0]  TRIG_BOTH       = 2'h2;
  localparam logic [1:0]  RATE_DIV1       = 2'h0;
  localparam logic [1:0]  RATE_DIV4       = 2'h1;
  localparam logic [1:0]  RATE_DIV8       = 2'h2;
  localparam logic [1:0]  RATE_DIV16      = 2'h3;

  // ==========================================================
  // filter timing
  localparam int unsigned GEAR_DIV_W      = 4;
  localparam logic [1:0]  SLOW_TICK_LAST  = 2'h3;
  localparam logic [1:0]  FILTER_SAMPLES  = 2'h3;

endpackage

`default_nettype wire

// ---- tb/ext_pin_model.sv ----
// far side model: external pin driver and low-frequency tick source
`default_nettype none

// ==========================================================
// pin and slow tick model
module ext_pin_model #(
  parameter int LF_DIV = 5
) (
  input  wire logic clk_sys,
  input  wire logic pin_level,
  output var  logic ext_pin,
  output var  logic lf_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  // outputs settle at the first edge, well inside reset
  int lf_cnt = 0;

  // pin lags the requested level by one cycle, like an input stage
  always @(posedge clk_sys) begin
    ext_pin <= pin_level;
  end

  // slow oscillator runs free, also through reset: it is not ours
  always @(posedge clk_sys) begin
    if (lf_cnt == LF_DIV - 1) begin
      lf_cnt  <= 0;
      lf_tick <= 1'b1;
    end else begin
      lf_cnt  <= lf_cnt + 1;
      lf_tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ---- tb/external_interrupt_detect_tb_top.sv ----
// testbench for the external interrupt detect block
`default_nettype none

// ==========================================================
// bench top
module external_interrupt_detect_tb_top;
  import ext_int_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LF_DIV = 5;

  logic              clk_sys;
  logic              nrst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              ext_pin;
  logic              mode_slow;
  logic              lf_tick;
  logic              int_ack;
  logic              irq;
  logic              pin_level;
  int                n_mismatch;
  int                n_tests;
  int                cycles;
  int                dv;

  external_interrupt_detect DUT (
    .clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ext_pin(ext_pin),
    .mode_slow(mode_slow), .lf_tick(lf_tick), .int_ack(int_ack),
    .irq(irq));

  ext_pin_model #(.LF_DIV(LF_DIV)) far_side (
    .clk_sys(clk_sys), .pin_level(pin_level), .ext_pin(ext_pin),
    .lf_tick(lf_tick));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // whole sequence needs under a thousand cycles; far below the ceiling
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ==========================================================
  // compare, bus and pin tasks
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    #1;
    check8(rdata, exp);
  endtask

  // mask off around a control rewrite, so no stray request is kept
  task automatic setup(input logic [7:0] ctrl);
    wr_reg(MASK_ADDR, 8'h00);
    wr_reg(CTRL1_ADDR, ctrl);
    wr_reg(STATUS_ADDR, 8'h01);
    wr_reg(MASK_ADDR, 8'h01);
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    pin_level <= v;
  endtask

  task automatic wait_irq(input int lo, input int hi);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check1(n >= lo && n <= hi, 1'b1);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
    check1(irq, 1'b0);
  endtask

  task automatic clr;
    wr_reg(STATUS_ADDR, 8'h01);
    quiet(2);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    n_tests    = 0;
    nrst       = 1'b0;
    addr       = '0;
    wdata      = '0;
    wr         = 1'b0;
    rd         = 1'b0;
    mode_slow  = 1'b0;
    int_ack    = 1'b0;
    pin_level  = 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_check(ENABLES_ADDR, 8'h00);
    rd_check(CTRL1_ADDR, 8'h00);
    rd_check(12'h000, 8'h00);
    wr_reg(CTRL1_ADDR, 8'h03);
    rd_check(CTRL1_ADDR, 8'h00);
    wr_reg(ENABLES_ADDR, 8'hFF);
    rd_check(ENABLES_ADDR, 8'h3F);
    wr_reg(ENABLES_ADDR, 8'h02);
    rd_check(ENABLES_ADDR, 8'h02);
    wr_reg(CTRL1_ADDR, 8'hFF);
    rd_check(CTRL1_ADDR, 8'h0F);
    setup(8'h00);
    set_pin(1'b1);
    wait_irq(2, 11);
    rd_check(STATUS_ADDR, 8'h01);
    rd_check(CTRL1_ADDR, 8'h10);
    check1(irq, 1'b1);
    clr();
    setup(8'h04);
    set_pin(1'b0);
    wait_irq(2, 11);
    rd_check(CTRL1_ADDR, 8'h04);
    wr_reg(MASK_ADDR, 8'h00);
    quiet(2);
    wr_reg(MASK_ADDR, 8'h01);
    rd_check(MASK_ADDR, 8'h01);
    check1(irq, 1'b1);
    @(posedge clk_sys);
    int_ack <= 1'b1;
    @(posedge clk_sys);
    int_ack <= 1'b0;
    quiet(2);
    set_pin(1'b1);
    set_pin(1'b1);
    set_pin(1'b0);
    quiet(20);
    setup(8'h08);
    set_pin(1'b1);
    wait_irq(2, 11);
    clr();
    set_pin(1'b0);
    wait_irq(2, 11);
    setup(8'h0C);
    set_pin(1'b1);
    quiet(20);
    set_pin(1'b0);
    quiet(20);
    for (int r = 0; r < 4; r++) begin
      dv = (r == 0) ? 1 : (1 << (r + 1));
      setup({6'h00, r[1:0]});
      set_pin(1'b1);
      wait_irq(2 * dv, 3 * dv + 8);
      clr();
      set_pin(1'b0);
      quiet(3 * dv + 10);
    end
    wr_reg(MASK_ADDR, 8'h00);
    @(posedge clk_sys);
    mode_slow <= 1'b1;
    repeat (12 * LF_DIV) @(posedge clk_sys);
    setup(8'h00);
    set_pin(1'b1);
    wait_irq(8 * LF_DIV, 12 * LF_DIV + 8);
    clr();
    set_pin(1'b0);
    quiet(16 * LF_DIV);
    wr_reg(MASK_ADDR, 8'h00);
    @(posedge clk_sys);
    mode_slow <= 1'b0;
    repeat (40) @(posedge clk_sys);
    wr_reg(ENABLES_ADDR, 8'h00);
    wr_reg(STATUS_ADDR, 8'h01);
    wr_reg(MASK_ADDR, 8'h01);
    set_pin(1'b1);
    quiet(20);
    rd_check(STATUS_ADDR, 8'h00);
    final_report();
  end
endmodule

`default_nettype wire
